// ### hdl/srr_consts.vh
// Shared constants for the ringing and ram register bank.
// Assumes an 8-bit register port with hexadecimal register addresses.
`ifndef SRR_CONSTS_VH
`define SRR_CONSTS_VH
`define SRR_ADDR_SOFT_RESET  8'h01
`define SRR_ADDR_RAM_STATUS  8'h04
`define SRR_ADDR_RING_CONFIG 8'h17
`define SRR_ADDR_RAM_DATA_LO 8'h65
`define SRR_ADDR_RAM_DATA_HI 8'h66
`define SRR_ADDR_RAM_ADDR    8'h67
`define SRR_RING_WAVE_BIT    7
`define SRR_RING_DAC_BIT     6
`define SRR_RING_UNB_BIT     5
`define SRR_RING_TON_BIT     4
`define SRR_RING_TOFF_BIT    3
`define SRR_RING_OSC_BIT     2
`define SRR_RING_POL_BIT     1
`define SRR_RING_TRAP_BIT    0
`define SRR_RING_WR_MASK     8'h3b
`define SRR_RESET_VAL        8'h00
`define SRR_UPDATE_DIV       8'h10
`define SRR_STEP_NS          1250
`define SRR_CLK_NS           10
`define SRR_STEP_CYCLES      ((`SRR_STEP_NS + `SRR_CLK_NS - 1) / `SRR_CLK_NS)
`endif

// ### hdl/srr_param_ram.v
// Internal parameter ram, flip-flop storage with index addressing.
// Assumes write and clear requests come from the register bank.
`timescale 1ns/1ps
module srr_param_ram #(
    parameter AW = 8,
    parameter DW = 16
) (
    // clock and reset
    input  wire          i_sys_clk,
    input  wire          i_rst,
    // access
    input  wire          i_clear,
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    output wire [DW-1:0] o_rdata
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];
    genvar g;
    generate
        for (g = 0; g < (1<<AW); g = g + 1) begin : g_word
            always @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    mem_r[g] <= {DW{1'b0}};
                end else if (i_clear) begin
                    mem_r[g] <= {DW{1'b0}};
                end else if (i_we && ({{(32-AW){1'b0}}, i_addr} == g)) begin
                    mem_r[g] <= i_wdata;
                end
            end
        end
    endgenerate
    assign o_rdata = mem_r[i_addr];
endmodule // srr_param_ram

// ### hdl/srr_cadence_timer.v
// Ringing burst cadence timer for one channel.
// Assumes 16-bit on and off periods in 1.25 us steps.
`timescale 1ns/1ps
`include "srr_consts.vh"
module srr_cadence_timer #(
    parameter STEP_CYCLES = `SRR_STEP_CYCLES
) (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // control
    input  wire        i_ring_req,
    input  wire        i_on_en,
    input  wire        i_off_en,
    input  wire [15:0] i_on_time,
    input  wire [15:0] i_off_time,
    // status
    output reg         o_osc_on
);
    // prescaler terminal count, cut to the prescaler width on purpose
    localparam integer STEP_M1_I = STEP_CYCLES - 1;
    localparam [7:0]   STEP_M1   = STEP_M1_I[7:0];
    reg [7:0]  pre_r;
    reg [15:0] cnt_r;
    wire       tick = (pre_r == STEP_M1);
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_r    <= 8'h00;
            cnt_r    <= 16'h0000;
            o_osc_on <= 1'b0;
        end else if (!i_ring_req) begin
            pre_r    <= 8'h00;
            cnt_r    <= 16'h0000;
            o_osc_on <= 1'b0;
        end else begin
            pre_r <= tick ? 8'h00 : pre_r + 8'h01;
            if (tick) begin
                if (o_osc_on && i_on_en) begin
                    if (cnt_r >= i_on_time) begin
                        cnt_r    <= 16'h0000;
                        o_osc_on <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end else if (!o_osc_on) begin
                    if (!i_off_en || cnt_r >= i_off_time) begin
                        cnt_r    <= 16'h0000;
                        o_osc_on <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
            end
        end
    end
endmodule // srr_cadence_timer

// ### hdl/srr_regs.v
// Register bank: indirect ram access, channel soft reset, ringing config.
// Assumes a one-cycle register port strobe; one channel selected per access.
`timescale 1ns/1ps
`include "srr_consts.vh"
module srr_regs #(
    parameter UPDATE_DIV  = `SRR_UPDATE_DIV,
    parameter STEP_CYCLES = `SRR_STEP_CYCLES
) (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // register port
    input  wire        i_chan_sel,
    input  wire [7:0]  i_reg_addr,
    input  wire        i_reg_wr,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    // ringing engine
    input  wire [1:0]  i_ring_req,
    input  wire [1:0]  i_ring_to_dac,
    input  wire [15:0] i_on_time_a,
    input  wire [15:0] i_off_time_a,
    input  wire [15:0] i_on_time_b,
    input  wire [15:0] i_off_time_b,
    output wire [1:0]  o_ring_osc_on,
    output wire [1:0]  o_unbalanced_ring_enable,
    output wire [1:0]  o_unbalanced_reverse_polarity,
    output wire [1:0]  o_trapezoid_select,
    // resets out
    output reg  [1:0]  o_chan_reset,
    output reg         o_pll_reinit
);
    ////////////////////////////////////////////////////////////////////////////
    // register state
    reg  [7:0] ram_data_low_byte_r;
    reg  [7:0] ram_data_high_byte_r;
    reg  [7:0] ram_target_address_r;
    reg        ram_access_pending_r;
    reg        ram_is_write_r;
    reg        data_dirty_r;
    reg  [7:0] upd_cnt_r;
    reg  [7:0] ring_cfg_r [0:1];
    reg  [1:0] soft_reset_r;
    wire [15:0] ram_rdata;
    // update terminal count, cut to the counter width on purpose
    localparam integer UPD_M1_I = UPDATE_DIV - 1;
    localparam [7:0]   UPD_M1   = UPD_M1_I[7:0];
    wire       upd_tick = (upd_cnt_r == UPD_M1);
    wire       full_reset = o_chan_reset[0] & o_chan_reset[1];
    wire       ram_we = upd_tick & ram_access_pending_r & ram_is_write_r;
    wire       ch = i_chan_sel;

    function is_reg;
        input [7:0] a;
        input [7:0] b;
        is_reg = (a == b);
    endfunction

    wire wr_data_lo = i_reg_wr & is_reg(i_reg_addr, `SRR_ADDR_RAM_DATA_LO);
    wire wr_data_hi = i_reg_wr & is_reg(i_reg_addr, `SRR_ADDR_RAM_DATA_HI);
    wire wr_addr    = i_reg_wr & is_reg(i_reg_addr, `SRR_ADDR_RAM_ADDR);
    wire wr_reset   = i_reg_wr & is_reg(i_reg_addr, `SRR_ADDR_SOFT_RESET);
    wire wr_ring    = i_reg_wr & is_reg(i_reg_addr, `SRR_ADDR_RING_CONFIG);

    ////////////////////////////////////////////////////////////////////////////
    // memory update cycle and indirect access
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            upd_cnt_r <= 8'h00;
        end else begin
            upd_cnt_r <= upd_tick ? 8'h00 : upd_cnt_r + 8'h01;
        end
    end

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ram_data_low_byte_r  <= `SRR_RESET_VAL;
            ram_data_high_byte_r <= `SRR_RESET_VAL;
            ram_target_address_r <= `SRR_RESET_VAL;
            ram_access_pending_r <= 1'b0;
            ram_is_write_r       <= 1'b0;
            data_dirty_r         <= 1'b0;
        end else if (full_reset) begin
            ram_data_low_byte_r  <= `SRR_RESET_VAL;
            ram_data_high_byte_r <= `SRR_RESET_VAL;
            ram_target_address_r <= `SRR_RESET_VAL;
            ram_access_pending_r <= 1'b0;
            ram_is_write_r       <= 1'b0;
            data_dirty_r         <= 1'b0;
        end else begin
            if (wr_addr) begin
                ram_target_address_r <= i_reg_wdata;
                ram_access_pending_r <= 1'b1;
                ram_is_write_r       <= data_dirty_r | wr_data_lo | wr_data_hi;
                data_dirty_r         <= 1'b0;
            end else if (upd_tick && ram_access_pending_r) begin
                ram_access_pending_r <= 1'b0;
                if (!ram_is_write_r) begin
                    ram_data_high_byte_r <= ram_rdata[15:8];
                    ram_data_low_byte_r  <= ram_rdata[7:0];
                end
            end
            if (wr_data_lo) begin
                ram_data_low_byte_r <= i_reg_wdata;
                data_dirty_r        <= ~wr_addr;
            end
            if (wr_data_hi) begin
                ram_data_high_byte_r <= i_reg_wdata;
                data_dirty_r         <= ~wr_addr;
            end
        end
    end

    srr_param_ram #(
        .AW (8),
        .DW (16)
    ) u_ram (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (full_reset),
        .i_we      (ram_we),
        .i_addr    (ram_target_address_r),
        .i_wdata   ({ram_data_high_byte_r, ram_data_low_byte_r}),
        .o_rdata   (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // soft reset: one-cycle pulse per written bit, both means full reset
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            soft_reset_r <= 2'b00;
            o_chan_reset <= 2'b00;
            o_pll_reinit <= 1'b0;
        end else begin
            soft_reset_r <= 2'b00;
            o_chan_reset <= 2'b00;
            o_pll_reinit <= 1'b0;
            if (wr_reset) begin
                soft_reset_r <= i_reg_wdata[1:0];
                o_chan_reset <= i_reg_wdata[1:0];
                o_pll_reinit <= &i_reg_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel ringing configuration and cadence
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_chan
            always @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    ring_cfg_r[c] <= `SRR_RESET_VAL;
                end else if (o_chan_reset[c]) begin
                    ring_cfg_r[c] <= `SRR_RESET_VAL;
                end else if (wr_ring && ({31'h0, ch} == c)) begin
                    ring_cfg_r[c] <= i_reg_wdata & `SRR_RING_WR_MASK;
                end
            end
            srr_cadence_timer #(
                .STEP_CYCLES (STEP_CYCLES)
            ) u_cad (
                .i_sys_clk  (i_sys_clk),
                .i_rst      (i_rst),
                .i_ring_req (i_ring_req[c] & ~o_chan_reset[c]),
                .i_on_en    (ring_cfg_r[c][`SRR_RING_TON_BIT]),
                .i_off_en   (ring_cfg_r[c][`SRR_RING_TOFF_BIT]),
                .i_on_time  (c == 0 ? i_on_time_a : i_on_time_b),
                .i_off_time (c == 0 ? i_off_time_a : i_off_time_b),
                .o_osc_on   (o_ring_osc_on[c])
            );
            assign o_unbalanced_ring_enable[c]      = ring_cfg_r[c][`SRR_RING_UNB_BIT];
            assign o_unbalanced_reverse_polarity[c] = ring_cfg_r[c][`SRR_RING_POL_BIT];
            assign o_trapezoid_select[c]            = ring_cfg_r[c][`SRR_RING_TRAP_BIT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // readback; offsets without a register read zero
    reg [7:0] ring_rd;
    always @* begin
        ring_rd = ring_cfg_r[ch];
        ring_rd[`SRR_RING_WAVE_BIT] = i_ring_req[ch] & o_ring_osc_on[ch];
        ring_rd[`SRR_RING_DAC_BIT]  = i_ring_to_dac[ch];
        ring_rd[`SRR_RING_OSC_BIT]  = o_ring_osc_on[ch];
        case (i_reg_addr)
            `SRR_ADDR_SOFT_RESET:  o_reg_rdata = {6'h00, soft_reset_r};
            `SRR_ADDR_RAM_STATUS:  o_reg_rdata = {7'h00, ram_access_pending_r};
            `SRR_ADDR_RING_CONFIG: o_reg_rdata = ring_rd;
            `SRR_ADDR_RAM_DATA_LO: o_reg_rdata = ram_data_low_byte_r;
            `SRR_ADDR_RAM_DATA_HI: o_reg_rdata = ram_data_high_byte_r;
            `SRR_ADDR_RAM_ADDR:    o_reg_rdata = ram_target_address_r;
            default:               o_reg_rdata = 8'h00;
        endcase
    end
endmodule // srr_regs

// ### tb/srr_regs_checker.sv
// checker for the ram, soft reset and ringing register bank
// assumes binding to srr_regs, single clock domain
`timescale 1ns/1ps
module srr_regs_checker #(
    parameter UPDATE_DIV  = 16,
    parameter STEP_CYCLES = 125
) (
    // clock and reset
    input wire       i_sys_clk,
    input wire       i_rst,
    // register port
    input wire       i_chan_sel,
    input wire [7:0] i_reg_addr,
    input wire       i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    // ringing and resets
    input wire [1:0] i_ring_to_dac,
    input wire [1:0] o_ring_osc_on,
    input wire [1:0] o_unbalanced_ring_enable,
    input wire [1:0] o_unbalanced_reverse_polarity,
    input wire [1:0] o_trapezoid_select,
    input wire [1:0] o_chan_reset,
    input wire       o_pll_reinit
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_stat; i_reg_addr == 8'h04 |-> o_reg_rdata[7:1] == 7'h00; endproperty
    a_stat: assert property (p_stat) else $error("status upper bits set");
    property p_busy; i_reg_wr && i_reg_addr == 8'h67 ##1 i_reg_addr == 8'h04
        |-> o_reg_rdata[0]; endproperty
    a_busy: assert property (p_busy) else $error("no busy after address write");
    property p_crst; i_reg_wr && i_reg_addr == 8'h01
        |=> o_chan_reset == $past(i_reg_wdata[1:0]); endproperty
    a_crst: assert property (p_crst) else $error("channel reset mismatch");
    property p_once; o_chan_reset != 2'b00 |=> o_chan_reset == 2'b00; endproperty
    a_once: assert property (p_once) else $error("channel reset too long");
    property p_pll; o_pll_reinit == (o_chan_reset == 2'b11); endproperty
    a_pll: assert property (p_pll) else $error("full reset mismatch");
    property p_unb; i_reg_wr && i_reg_addr == 8'h17 |=>
        o_unbalanced_ring_enable[$past(i_chan_sel)] == $past(i_reg_wdata[5]); endproperty
    a_unb: assert property (p_unb) else $error("unbalanced enable mismatch");
    property p_pol; i_reg_wr && i_reg_addr == 8'h17 |=>
        o_unbalanced_reverse_polarity[$past(i_chan_sel)] == $past(i_reg_wdata[1]); endproperty
    a_pol: assert property (p_pol) else $error("polarity mismatch");
    property p_trap; i_reg_wr && i_reg_addr == 8'h17 |=>
        o_trapezoid_select[$past(i_chan_sel)] == $past(i_reg_wdata[0]); endproperty
    a_trap: assert property (p_trap) else $error("waveform select mismatch");
    property p_osc; i_reg_addr == 8'h17 |-> o_reg_rdata[2] == o_ring_osc_on[i_chan_sel];
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator bit mismatch");
    property p_dac; i_reg_addr == 8'h17 && $stable(i_ring_to_dac)
        |-> o_reg_rdata[6] == i_ring_to_dac[i_chan_sel]; endproperty
    a_dac: assert property (p_dac) else $error("dac routing bit mismatch");
endmodule // srr_regs_checker

// ### tb/test_srr_regs.sv
// self-checking bench for srr_regs
// assumes short cadence steps; reads compared by a queue monitor
`timescale 1ns/1ps
module test_srr_regs;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        wr = 1'b0;
    logic        rd_v = 1'b0;
    logic        p = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic [1:0]  req = 2'b00;
    logic [1:0]  dac = 2'b00;
    logic [15:0] tm = 16'h0003;
    logic [15:0] e;
    logic [15:0] q[$];
    logic [7:0]  ra[4];
    logic [15:0] rw[4];
    wire  [7:0]  rdata;
    wire  [1:0]  osc, unb, pol, trap, crst;
    wire         pll;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    srr_regs #(.UPDATE_DIV(16), .STEP_CYCLES(2)) dut (.i_sys_clk(clk), .i_rst(rst),
        .i_chan_sel(sel), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
        .o_reg_rdata(rdata), .i_ring_req(req), .i_ring_to_dac(dac), .i_on_time_a(tm),
        .i_off_time_a(tm), .i_on_time_b(tm), .i_off_time_b(tm), .o_ring_osc_on(osc),
        .o_unbalanced_ring_enable(unb), .o_unbalanced_reverse_polarity(pol),
        .o_trapezoid_select(trap), .o_chan_reset(crst), .o_pll_reinit(pll));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        @(negedge clk);
        addr = a;
        rd_v = 1'b1;
        q.push_back({m, x & m});
        @(negedge clk);
        rd_v = 1'b0;
    endtask
    // poll status right after an address write, bounded at 18 cycles, just over one 16-cycle update period
    task automatic idle();
        addr = 8'h04;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rdata[0] !== 1'b0 && n < 18);
        cmp({7'h00, rdata[0]}, 8'h00);
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) if (rd_v) begin
        #1;
        e = q.pop_front();
        cmp(rdata & e[15:8], e[7:0]);
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h31c8));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd(8'h04, 8'hff, 8'h00);
        rd(8'h66, 8'hff, 8'h00);
        rd(8'h17, 8'hff, 8'h00);
        rd(8'h68, 8'hff, 8'h00);
        for (int k = 0; k < 4; k++) begin
            ra[k] = {6'($urandom), 2'(k)};
            rw[k] = 16'($urandom);
            wrr(8'h65, rw[k][7:0]);
            wrr(8'h66, rw[k][15:8]);
            wrr(8'h67, ra[k]);
            idle();
        end
        for (int k = 0; k < 4; k++) begin
            wrr(8'h67, ra[k]);
            idle();
            rd(8'h65, 8'hff, rw[k][7:0]);
            rd(8'h66, 8'hff, rw[k][15:8]);
            rd(8'h67, 8'hff, ra[k]);
        end
        sel = 1'b1;
        wrr(8'h17, 8'h21);
        sel = 1'b0;
        wrr(8'h17, 8'hff);
        rd(8'h17, 8'hff, 8'h3b);
        wrr(8'h01, 8'h01);
        rd(8'h01, 8'hff, 8'h00);
        rd(8'h17, 8'hff, 8'h00);
        sel = 1'b1;
        rd(8'h17, 8'hff, 8'h21);
        wrr(8'h67, ra[0]);
        idle();
        rd(8'h65, 8'hff, rw[0][7:0]);
        wrr(8'h01, 8'h03);
        rd(8'h17, 8'hff, 8'h00);
        wrr(8'h67, ra[1]);
        idle();
        rd(8'h65, 8'hff, 8'h00);
        rd(8'h66, 8'hff, 8'h00);
        sel = 1'b0;
        tm = 16'd1 + 16'($urandom % 4);
        dac = 2'($urandom);
        wrr(8'h17, 8'h18);
        req = 2'b11;
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (osc[0] !== p) n++;
            p = osc[0];
        end
        cmp(8'(n >= 6 && n <= 100 / (2 * tm) + 2), 8'h01);
        wrr(8'h17, 8'h00);
        repeat (40) @(negedge clk);
        rd(8'h17, 8'hc4, {1'b1, dac[0], 6'h04});
        sel = 1'b1;
        rd(8'h17, 8'hc4, {1'b1, dac[1], 6'h04});
        req = 2'b00;
        repeat (10) @(negedge clk);
        rd(8'h17, 8'h80, 8'h00);
        repeat (3) @(negedge clk);
        test_done();
    end
endmodule // test_srr_regs
bind srr_regs srr_regs_checker #(.UPDATE_DIV(UPDATE_DIV), .STEP_CYCLES(STEP_CYCLES)) chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_chan_sel(i_chan_sel), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_ring_to_dac(i_ring_to_dac), .o_ring_osc_on(o_ring_osc_on),
    .o_unbalanced_ring_enable(o_unbalanced_ring_enable),
    .o_unbalanced_reverse_polarity(o_unbalanced_reverse_polarity),
    .o_trapezoid_select(o_trapezoid_select), .o_chan_reset(o_chan_reset),
    .o_pll_reinit(o_pll_reinit));
